// ---- hw/gpio_pkg.sv ----
// Overview of operation
// - two control registers, one per bank; bits 7-4 direction, bits 3-0 value
// - direction bit 0 makes the pin an input, 1 a driven output
// - after reset bank zero directions are 1111, bank one directions 0000
// - after reset both value nibbles are 0000, so outputs start low
// - input pin: reading its value bit returns the sampled pin level
// - output pin: driven to the level last written to its value bit
// - writing the value bit of an input pin never drives the pin
// - direction may change any time, applied to each pin individually
package gpio_pkg;
  // ==========================================
  // register map
  localparam int unsigned AddrWidth = 4;
  localparam int unsigned DataWidth = 8;
  localparam int unsigned PinsPerBank = 4;
  localparam int unsigned NumBanks = 2;
  localparam logic [3:0] PinBankZeroControlOffset = 4'h0;
  localparam logic [3:0] PinBankOneControlOffset = 4'h1;
  // ==========================================
  // field layout
  localparam int unsigned DirLsb = 4;
  localparam int unsigned ValueLsb = 0;
  // ==========================================
  // reset values
  localparam logic [3:0] BankZeroDirReset = 4'hF;
  localparam logic [3:0] BankOneDirReset = 4'h0;
  localparam logic [3:0] ValueReset = 4'h0;
  localparam logic [7:0] UnmappedReadData = 8'h00;
endpackage : gpio_pkg

// ---- hw/pin_bank.sv ----
module pin_bank
  import gpio_pkg::*;
#(
  parameter logic [3:0] DirResetValue = 4'h0
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic writeEn,
  input wire logic [7:0] writeData,
  input wire logic [3:0] pinIn,
  output logic [7:0] readValue,
  output logic [3:0] pinOut,
  output logic [3:0] pinOutEnN
);
  logic [3:0] dir_q;
  logic [3:0] dir_d;
  logic [3:0] value_q;
  logic [3:0] value_d;
  logic [3:0] pinMeta_q;
  logic [3:0] pinMeta_d;
  logic [3:0] pinSync_q;
  logic [3:0] pinSync_d;
  logic [3:0] pinOut_q;
  logic [3:0] pinOut_d;
  logic [3:0] pinOutEnN_q;
  logic [3:0] pinOutEnN_d;

  // ==========================================
  // control state and pin drivers
  always_comb
  begin
    dir_d = dir_q;
    value_d = value_q;
    if (writeEn)
    begin
      dir_d = writeData[DirLsb +: PinsPerBank];
      // value latch is kept even for inputs; only the enable gates the pin
      value_d = writeData[ValueLsb +: PinsPerBank];
    end
    // drive follows the new settings, so output pins have no extra lag
    pinOut_d = value_d;
    pinOutEnN_d = ~dir_d;
    pinMeta_d = pinIn;
    pinSync_d = pinMeta_q;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dir_q <= DirResetValue;
      value_q <= ValueReset;
      pinOut_q <= ValueReset;
      pinOutEnN_q <= ~DirResetValue;
      pinMeta_q <= 4'h0;
      pinSync_q <= 4'h0;
    end
    else
    begin
      dir_q <= dir_d;
      value_q <= value_d;
      pinOut_q <= pinOut_d;
      pinOutEnN_q <= pinOutEnN_d;
      pinMeta_q <= pinMeta_d;
      pinSync_q <= pinSync_d;
    end
  end

  // ==========================================
  // readback: per pin, sampled level for inputs, latch for outputs
  always_comb
  begin
    readValue = {dir_q, (dir_q & value_q) | (~dir_q & pinSync_q)};
  end

  assign pinOut = pinOut_q;
  assign pinOutEnN = pinOutEnN_q;
endmodule : pin_bank

// ---- hw/general_purpose_pin_port.sv ----
// The register offsets and the plain strobed port were left to the implementer.
module general_purpose_pin_port
  import gpio_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOutEnN
);
  // ==========================================
  // address decode shared by write and read paths
  function automatic logic [1:0] decodeBank(input logic [3:0] addr);
    logic [1:0] hit;
    hit = 2'h0;
    if (addr == PinBankZeroControlOffset)
    begin
      hit = 2'h1;
    end
    else if (addr == PinBankOneControlOffset)
    begin
      hit = 2'h2;
    end
    return hit;
  endfunction : decodeBank

  logic [1:0] writeHit;
  logic [1:0] readHit;
  logic [7:0] bankRead [NumBanks];
  logic [7:0] regReadData_q;
  logic [7:0] regReadData_d;

  // ==========================================
  // one bank instance per register
  always_comb
  begin
    writeHit = regWrite ? decodeBank(regAddr) : 2'h0;
    readHit = decodeBank(regAddr);
  end

  pin_bank #(
    .DirResetValue(BankZeroDirReset)
  ) bankZero (
    .core_clk(core_clk),
    .rst(rst),
    .writeEn(writeHit[0]),
    .writeData(regWriteData),
    .pinIn(pinIn[3:0]),
    .readValue(bankRead[0]),
    .pinOut(pinOut[3:0]),
    .pinOutEnN(pinOutEnN[3:0])
  );

  pin_bank #(
    .DirResetValue(BankOneDirReset)
  ) bankOne (
    .core_clk(core_clk),
    .rst(rst),
    .writeEn(writeHit[1]),
    .writeData(regWriteData),
    .pinIn(pinIn[7:4]),
    .readValue(bankRead[1]),
    .pinOut(pinOut[7:4]),
    .pinOutEnN(pinOutEnN[7:4])
  );

  // ==========================================
  // read data valid only the cycle after the strobe; zero otherwise
  always_comb
  begin
    regReadData_d = 8'h00;
    if (regRead)
    begin
      regReadData_d = UnmappedReadData;
      if (readHit[0])
      begin
        regReadData_d = bankRead[0];
      end
      else if (readHit[1])
      begin
        regReadData_d = bankRead[1];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      regReadData_q <= 8'h00;
    end
    else
    begin
      regReadData_q <= regReadData_d;
    end
  end

  assign regReadData = regReadData_q;
endmodule : general_purpose_pin_port

// ---- bench/board_pins.sv ----
module board_pins
(
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOutEnN,
  input wire logic [7:0] board,
  output logic [7:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // the device wins where it drives, the board everywhere else
  assign pinIn = (pinOut & ~pinOutEnN) | (board & pinOutEnN);
endmodule : board_pins

// ---- bench/general_purpose_pin_port_monitor.sv ----
module gpio_monitor
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOutEnN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ====
  // read timing, decode and write effects
  property p_idle; !regRead |=> regReadData == 0; endproperty
  property p_w0; regWrite && regAddr == 0 |=> pinOutEnN[3:0] == ~$past(regWriteData[7:4])
    && ((pinOut[3:0] ^ $past(regWriteData[3:0])) & ~pinOutEnN[3:0]) == 0; endproperty
  property p_w1; regWrite && regAddr == 1 |=> pinOutEnN[7:4] == ~$past(regWriteData[7:4])
    && ((pinOut[7:4] ^ $past(regWriteData[3:0])) & ~pinOutEnN[7:4]) == 0; endproperty
  property p_hold; !regWrite |=> $stable(pinOutEnN) && $stable(pinOut); endproperty
  property p_r0; regRead && regAddr == 0 |=> regReadData[7:4] == ~$past(pinOutEnN[3:0])
    && ((regReadData[3:0] ^ $past(pinOut[3:0])) & ~$past(pinOutEnN[3:0])) == 0; endproperty
  property p_r1; regRead && regAddr == 1 |=> regReadData[7:4] == ~$past(pinOutEnN[7:4]); endproperty
  property p_unm; regRead && regAddr > 1 |=> regReadData == 0; endproperty
  sequence s_calm; $stable(pinIn)[*4] ##0 regRead && regAddr == 1; endsequence
  property p_in; s_calm |=> ((regReadData[3:0] ^ $past(pinIn[7:4])) & $past(pinOutEnN[7:4])) == 0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  a_w0: assert property (p_w0) else $error("bank zero write not applied");
  a_w1: assert property (p_w1) else $error("bank one write not applied");
  a_hold: assert property (p_hold) else $error("pins moved without write");
  a_r0: assert property (p_r0) else $error("bank zero readback wrong");
  a_r1: assert property (p_r1) else $error("bank one direction readback wrong");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_in: assert property (p_in) else $error("input level not read back");
endmodule : gpio_monitor
bind general_purpose_pin_port gpio_monitor mon_u (.*);

// ---- bench/general_purpose_pin_port_test.sv ----
module general_purpose_pin_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst = 1, regWrite = 0, regRead = 0;
  logic [3:0] regAddr = 0;
  logic [7:0] regWriteData = 0, board = 8'hA5, regReadData, pinIn, pinOut, pinOutEnN;
  int numErrors = 0, nTests = 0, cyc = 0;
  general_purpose_pin_port dut_u (.*);
  board_pins pb_u (.pinOut(pinOut), .pinOutEnN(pinOutEnN), .board(board), .pinIn(pinIn));
  // ====
  // clock and a ceiling well above the run length
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 500)
    begin
      numErrors++;
      conclude();
    end
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    nTests++;
    if (s !== e)
    begin
      numErrors++;
      $display("unexpected %0t %h %h", $time, s, e);
    end
  endtask : chk
  // bus tasks leave a free edge so no strobe is set twice in one step
  task wr(input logic [3:0] a, input logic [7:0] d);
    regWrite <= 1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge core_clk);
    regWrite <= 0;
    @(posedge core_clk);
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    regRead <= 1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 0;
    #1 chk(regReadData, e);
    @(posedge core_clk);
  endtask : rd
  task conclude;
    $display("errors %0d checks %0d", numErrors, nTests);
    if (numErrors == 0 && nTests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // ====
  // main sequence
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 0;
    repeat (3) @(posedge core_clk);
    chk(pinOutEnN, 8'hF0);
    chk(pinOut & ~pinOutEnN, 8'h00);
    rd(0, 8'hF0);
    rd(1, 8'h0A);
    wr(1, 8'h35);
    chk(pinOutEnN, 8'hC0);
    rd(1, 8'h39);
    board <= 8'h5A;
    repeat (3) @(posedge core_clk);
    rd(1, 8'h35);
    wr(0, 8'h0C);
    chk(pinOutEnN, 8'hCF);
    repeat (2) @(posedge core_clk);
    rd(0, 8'h0A);
    wr(0, 8'hFC);
    chk(pinOut[3:0], 4'hC);
    rd(0, 8'hFC);
    rd(2, 8'h00);
    conclude();
  end
endmodule : general_purpose_pin_port_test
